//--- pkg/mode_seq_defs.vh
// Constants for the operating-mode and power sequencer.
// Assumes inclusion by bare name from the design files.
`ifndef MODE_SEQ_DEFS_VH
`define MODE_SEQ_DEFS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define REG_CTRL        5'h00
`define REG_CFG         5'h04
`define REG_POLL        5'h08
`define REG_WDOG        5'h0C
`define REG_STATUS      5'h10

// ****************************************
// Control register fields
// ****************************************
`define CTRL_CMD_LSB    0
`define CTRL_CMD_MSB    2
`define CTRL_KICK_BIT   8
`define CTRL_ABORT_BIT  9
`define CTRL_DONE_BIT   10

// ****************************************
// Command codes
// ****************************************
`define CMD_NONE        3'h0
`define CMD_TX          3'h1
`define CMD_RX          3'h2
`define CMD_POLL        3'h3
`define CMD_TC          3'h4
`define CMD_IDLE        3'h5

// ****************************************
// Configuration fields and reset values
// ****************************************
`define CFG_XTO_BIT     0
`define CFG_PD_BIT      1
`define CFG_START_LSB   4
`define CFG_START_MSB   6
`define CFG_TC_INIT_BIT 8
`define CFG_TC_POLL_BIT 9
`define CFG_RESET       32'h0000_0002
`define POLL_RESET      32'h0010_0010
`define WDOG_RESET      32'h0001_0000

// ****************************************
// Timing
// ****************************************
`define INIT_TIME_NS    1000
`define CLK_PERIOD_NS   5
`define TC_CYCLES       16'h0040
`define SEQ_CYCLES      8'h10

`endif

//--- rtl/pin_sync.v
// Three-flop pin synchroniser with agreement filter.
// Assumes an asynchronous pin and a single core clock.
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
	parameter RESET_LEVEL = 1'b0
) (
	// Clock and reset
	input  wire core_clk,
	input  wire arst_n,
	// Pin and result
	input  wire pin_in,
	output reg  level_ff
);

	reg meta_ff;
	reg s2_ff;
	reg s3_ff;

	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_ff  <= RESET_LEVEL;
			s2_ff    <= RESET_LEVEL;
			s3_ff    <= RESET_LEVEL;
			level_ff <= RESET_LEVEL;
		end else begin
			meta_ff <= pin_in;
			s2_ff   <= meta_ff;
			s3_ff   <= s2_ff;
			// Change counts only once two later stages agree
			if (s2_ff == s3_ff) begin
				level_ff <= s3_ff;
			end
		end
	end

endmodule

`default_nettype wire

//--- rtl/mode_seq.v
// Operating-mode and power sequencer with AXI4-Lite registers.
// Assumes a single 200 MHz core clock; wake pins are asynchronous.
//
// Functional notes
// - Supply applied: start in off state, all domains unpowered.
// - Off state ignores host bus traffic; host waits for wake.
// - Either wake pin polarity starts power-on; pins live while off.
// - After initialization the sequencer settles in idle unless start-up config picks tune-check or a mode.
// - Idle accepts commands and is the hub for every mode.
// - Config bit picks RC idle or crystal idle variant.
// - Transmit/receive entered by command or start-up config.
// - Receive searches; accepts data only on preamble and all checks.
// - Polling listens briefly, sleeps, repeats periodically.
// - Polling settings loaded at init; writable only in idle.
// - Tune-check by command, optionally at init and in polling.
// - RC idle: digital supply and slow RC; fast RC only when cpu not powered down.
// - Crystal idle adds analog supply and crystal oscillator.
// - Analog supply has no enable of its own; it switches with crystal_osc.
// - Polling sleep phase may use the idle power-down mode.
// - Idle cpu sleep mode from config; power-down recommended.
// - Path sequencer runs fixed-timing enable/disable alongside cpu.
// - Watchdog restarts device if not serviced before timeout.
`timescale 1ns/1ps
`default_nettype none
`include "mode_seq_defs.vh"

module mode_seq #(
	parameter INIT_CYCLES = (`INIT_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
	// Clock and reset
	input  wire        core_clk,
	input  wire        arst_n,
	// Wake pins
	input  wire        power_on_pin,
	input  wire        power_on_pin_low,
	// Receive path status
	input  wire        preamble_ok,
	input  wire        checks_ok,
	input  wire        telegram_end,
	// AXI4-Lite write
	input  wire [4:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	// AXI4-Lite read
	input  wire [4:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// Power and clock controls
	output reg         digital_supply_domain,
	output reg         analog_supply_domain,
	output reg         fast_rc_osc,
	output reg         slow_rc_osc,
	output reg         crystal_osc,
	output reg         cpu_power_down,
	output reg         rx_path_en,
	output reg         tx_path_en,
	output reg         data_accept,
	output reg         watchdog_restart
);

	// ****************************************
	// States
	// ****************************************
	localparam [2:0] ST_OFF  = 3'h0;
	localparam [2:0] ST_INIT = 3'h1;
	localparam [2:0] ST_IDLE = 3'h2;
	localparam [2:0] ST_TX   = 3'h3;
	localparam [2:0] ST_RX   = 3'h4;
	localparam [2:0] ST_POLL = 3'h5;
	localparam [2:0] ST_TC   = 3'h6;

	reg  [2:0]  state_ff;
	reg  [2:0]  nxt_state;
	reg  [31:0] cfg_ff;
	reg  [31:0] poll_ff;
	reg  [31:0] wdog_ff;
	reg  [31:0] cnt_ff;
	reg         poll_sleep_ff;
	reg  [7:0]  poll_n_ff;
	reg  [7:0]  seq_ff;
	reg  [31:0] wd_cnt_ff;
	reg         tc_return_poll_ff;
	wire        wake_hi;
	wire        wake_lo_n;

	// ****************************************
	// Wake pin synchronisers
	// ****************************************
	pin_sync #(.RESET_LEVEL(1'b0)) u_sync_hi (
		.core_clk (core_clk),
		.arst_n   (arst_n),
		.pin_in   (power_on_pin),
		.level_ff (wake_hi)
	);

	pin_sync #(.RESET_LEVEL(1'b1)) u_sync_lo (
		.core_clk (core_clk),
		.arst_n   (arst_n),
		.pin_in   (power_on_pin_low),
		.level_ff (wake_lo_n)
	);

	// ****************************************
	// AXI4-Lite slave
	// ****************************************
	reg        aw_hold_ff;
	reg        w_hold_ff;
	reg [4:0]  awaddr_ff;
	reg [31:0] wdata_ff;
	reg [3:0]  wstrb_ff;
	wire       bus_live = (state_ff != ST_OFF);
	wire       wr_go    = aw_hold_ff && w_hold_ff && !s_axi_bvalid;

	assign s_axi_awready = !aw_hold_ff && !s_axi_bvalid && bus_live;
	assign s_axi_wready  = !w_hold_ff && !s_axi_bvalid && bus_live;
	assign s_axi_arready = !s_axi_rvalid && bus_live;

	wire       wr_ctrl  = wr_go && (awaddr_ff == `REG_CTRL);
	wire [2:0] cmd      = wr_ctrl && wstrb_ff[0] ?
	                      wdata_ff[`CTRL_CMD_MSB:`CTRL_CMD_LSB] : `CMD_NONE;
	wire       kick     = wr_ctrl && wstrb_ff[1] && wdata_ff[`CTRL_KICK_BIT];
	wire       abort_op = wr_ctrl && wstrb_ff[1] && wdata_ff[`CTRL_ABORT_BIT];
	wire       done_op  = wr_ctrl && wstrb_ff[1] && wdata_ff[`CTRL_DONE_BIT];

	function [31:0] merge;
		input [31:0] old;
		input [31:0] dat;
		input [3:0]  stb;
		integer i;
		begin
			merge = old;
			for (i = 0; i < 4; i = i + 1) begin
				if (stb[i]) begin
					merge[i*8 +: 8] = dat[i*8 +: 8];
				end
			end
		end
	endfunction

	wire known_w = (awaddr_ff == `REG_CTRL) || (awaddr_ff == `REG_CFG) ||
	               (awaddr_ff == `REG_POLL) || (awaddr_ff == `REG_WDOG) ||
	               (awaddr_ff == `REG_STATUS);

	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			aw_hold_ff   <= 1'b0;
			w_hold_ff    <= 1'b0;
			awaddr_ff    <= 5'h00;
			wdata_ff     <= 32'h0000_0000;
			wstrb_ff     <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'h0;
			cfg_ff       <= `CFG_RESET;
			poll_ff      <= `POLL_RESET;
			wdog_ff      <= `WDOG_RESET;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_ff <= 1'b1;
				awaddr_ff  <= {s_axi_awaddr[4:2], 2'h0};
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_ff <= 1'b1;
				wdata_ff  <= s_axi_wdata;
				wstrb_ff  <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_hold_ff   <= 1'b0;
				w_hold_ff    <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= known_w ? 2'h0 : 2'h2;
				// Config and polling settings only change in idle; watchdog any time
				if (state_ff == ST_IDLE) begin
					if (awaddr_ff == `REG_CFG)
						cfg_ff <= merge(cfg_ff, wdata_ff, wstrb_ff);
					if (awaddr_ff == `REG_POLL)
						poll_ff <= merge(poll_ff, wdata_ff, wstrb_ff);
				end
				if (awaddr_ff == `REG_WDOG)
					wdog_ff <= merge(wdog_ff, wdata_ff, wstrb_ff);
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= 2'h0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= 2'h0;
			case ({s_axi_araddr[4:2], 2'h0})
				`REG_CTRL:   s_axi_rdata <= 32'h0000_0000;
				`REG_CFG:    s_axi_rdata <= cfg_ff;
				`REG_POLL:   s_axi_rdata <= poll_ff;
				`REG_WDOG:   s_axi_rdata <= wdog_ff;
				`REG_STATUS: s_axi_rdata <= {16'h0000, poll_n_ff, 2'h0,
				                             poll_sleep_ff, data_accept,
				                             1'b0, state_ff};
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= 2'h2;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ****************************************
	// Mode state machine
	// ****************************************
	wire       xto_idle  = cfg_ff[`CFG_XTO_BIT];
	wire [2:0] start_cmd = cfg_ff[`CFG_START_MSB:`CFG_START_LSB];
	wire       wake      = wake_hi || !wake_lo_n;
	wire       cnt_zero  = (cnt_ff == 32'h0000_0000);
	wire       to_idle   = abort_op || (cmd == `CMD_IDLE);

	function [2:0] cmd_state;
		input [2:0] c;
		begin
			case (c)
				`CMD_TX:   cmd_state = ST_TX;
				`CMD_RX:   cmd_state = ST_RX;
				`CMD_POLL: cmd_state = ST_POLL;
				`CMD_TC:   cmd_state = ST_TC;
				default:   cmd_state = ST_IDLE;
			endcase
		end
	endfunction

	always @* begin
		nxt_state = state_ff;
		case (state_ff)
			ST_OFF:  if (wake) nxt_state = ST_INIT;
			ST_INIT: begin
				if (cnt_zero) begin
					if (cfg_ff[`CFG_TC_INIT_BIT])
						nxt_state = ST_TC;
					else
						nxt_state = cmd_state(start_cmd);
				end
			end
			ST_IDLE: nxt_state = cmd_state(cmd);
			ST_TX:   if (to_idle || done_op) nxt_state = ST_IDLE;
			ST_RX:   if (to_idle || done_op) nxt_state = ST_IDLE;
			ST_POLL: begin
				if (to_idle || (!poll_sleep_ff && telegram_end))
					nxt_state = ST_IDLE;
				else if (poll_sleep_ff && cnt_zero && cfg_ff[`CFG_TC_POLL_BIT] &&
				         poll_n_ff == 8'h00)
					nxt_state = ST_TC;
			end
			ST_TC: begin
				if (to_idle)
					nxt_state = ST_IDLE;
				else if (cnt_zero)
					nxt_state = tc_return_poll_ff ? ST_POLL : ST_IDLE;
			end
			default: nxt_state = ST_OFF;
		endcase
	end

	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_ff          <= ST_OFF;
			cnt_ff            <= 32'h0000_0000;
			poll_sleep_ff     <= 1'b0;
			poll_n_ff         <= 8'h00;
			tc_return_poll_ff <= 1'b0;
		end else if (watchdog_restart) begin
			state_ff <= ST_INIT;
			cnt_ff   <= INIT_CYCLES;
		end else begin
			state_ff <= nxt_state;
			if (nxt_state != state_ff) begin
				poll_sleep_ff <= 1'b0;
				case (nxt_state)
					ST_INIT: cnt_ff <= INIT_CYCLES;
					ST_TC: begin
						cnt_ff            <= {16'h0000, `TC_CYCLES};
						tc_return_poll_ff <= (state_ff == ST_POLL);
					end
					ST_POLL: begin
						cnt_ff    <= {16'h0000, poll_ff[15:0]};
						// Restart after a tune run too, else it repeats every sleep
						poll_n_ff <= poll_ff[31:24];
					end
					default: cnt_ff <= 32'h0000_0000;
				endcase
			end else if (state_ff == ST_POLL) begin
				if (!cnt_zero) begin
					cnt_ff <= cnt_ff - 32'h0000_0001;
				end else if (poll_sleep_ff) begin
					poll_sleep_ff <= 1'b0;
					cnt_ff        <= {16'h0000, poll_ff[15:0]};
					poll_n_ff     <= (poll_n_ff == 8'h00) ? poll_ff[31:24]
					                                      : poll_n_ff - 8'h01;
				end else begin
					// No telegram in listen window: sleep
					poll_sleep_ff <= 1'b1;
					cnt_ff        <= {16'h0000, poll_ff[23:16], 8'h00};
				end
			end else if (!cnt_zero) begin
				cnt_ff <= cnt_ff - 32'h0000_0001;
			end
		end
	end

	// ****************************************
	// Path sequencer, runs beside the cpu
	// ****************************************
	wire want_rx = (state_ff == ST_RX) || (state_ff == ST_POLL && !poll_sleep_ff);
	wire want_tx = (state_ff == ST_TX);

	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			seq_ff     <= 8'h00;
			rx_path_en <= 1'b0;
			tx_path_en <= 1'b0;
		end else if ((want_rx != rx_path_en) || (want_tx != tx_path_en)) begin
			// Fixed settle delay before each path switch
			if (seq_ff == `SEQ_CYCLES) begin
				seq_ff     <= 8'h00;
				rx_path_en <= want_rx;
				tx_path_en <= want_tx;
			end else begin
				seq_ff <= seq_ff + 8'h01;
			end
		end else begin
			seq_ff <= 8'h00;
		end
	end

	// ****************************************
	// Supplies, oscillators, data gate
	// ****************************************
	wire idle_like = (state_ff == ST_IDLE) || (state_ff == ST_POLL && poll_sleep_ff);

	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			digital_supply_domain <= 1'b0;
			analog_supply_domain  <= 1'b0;
			fast_rc_osc           <= 1'b0;
			slow_rc_osc           <= 1'b0;
			crystal_osc           <= 1'b0;
			cpu_power_down        <= 1'b0;
			data_accept           <= 1'b0;
		end else begin
			digital_supply_domain <= (state_ff != ST_OFF);
			slow_rc_osc           <= (state_ff != ST_OFF);
			if (idle_like) begin
				// RC variant: digital only; crystal variant adds analog
				analog_supply_domain <= xto_idle;
				crystal_osc          <= xto_idle;
				fast_rc_osc          <= !xto_idle && !cfg_ff[`CFG_PD_BIT];
				cpu_power_down       <= cfg_ff[`CFG_PD_BIT];
			end else begin
				analog_supply_domain <= (state_ff != ST_OFF) && (state_ff != ST_INIT);
				crystal_osc          <= (state_ff != ST_OFF) && (state_ff != ST_INIT);
				fast_rc_osc          <= (state_ff == ST_INIT) ||
				                        (state_ff == ST_POLL && !xto_idle);
				cpu_power_down       <= 1'b0;
			end
			data_accept <= rx_path_en && preamble_ok && checks_ok;
		end
	end

	// ****************************************
	// Watchdog
	// ****************************************
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			wd_cnt_ff        <= 32'h0000_0000;
			watchdog_restart <= 1'b0;
		end else if (kick || state_ff == ST_OFF || watchdog_restart) begin
			wd_cnt_ff        <= 32'h0000_0000;
			watchdog_restart <= 1'b0;
		end else if (wdog_ff != 32'h0000_0000 && wd_cnt_ff >= wdog_ff) begin
			watchdog_restart <= 1'b1;
		end else begin
			wd_cnt_ff <= wd_cnt_ff + 32'h0000_0001;
		end
	end

endmodule

`default_nettype wire

//--- verif/mode_seq_assertions.sv
// Port-level checker for the mode sequencer.
// Assumes binding onto mode_seq, one clock domain.
`timescale 1ns/1ps
`default_nettype none

module mode_seq_assertions (
	// Clock and reset
	input wire logic        core_clk,
	input wire logic        arst_n,
	// Bus and receive status
	input wire logic        preamble_ok,
	input wire logic        checks_ok,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	// Power controls
	input wire logic        digital_supply_domain,
	input wire logic        analog_supply_domain,
	input wire logic        crystal_osc,
	input wire logic        rx_path_en,
	input wire logic        tx_path_en,
	input wire logic        data_accept,
	input wire logic        watchdog_restart
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!arst_n);

	a_xtal_analog: assert property (crystal_osc |-> analog_supply_domain)
		else $error("crystal on without analog supply");
	a_analog_digital: assert property (analog_supply_domain |-> digital_supply_domain)
		else $error("analog supply on without digital");
	a_path_exclusive: assert property (!(rx_path_en && tx_path_en))
		else $error("both paths enabled");
	a_accept_cause: assert property ($rose(data_accept) |-> $past(preamble_ok) && $past(checks_ok))
		else $error("data accepted without preamble and checks");
	a_restart_pulse: assert property (watchdog_restart |=> !watchdog_restart)
		else $error("restart pulse too long");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read response changed");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
endmodule

bind mode_seq mode_seq_assertions u_chk (.*);
`default_nettype wire

//--- verif/host_model.sv
// Host microcontroller model: AXI4-Lite master tasks.
// Assumes the bench calls tasks right after a rising edge.
`timescale 1ns/1ps
`default_nettype none

module host_model (
	input  wire logic        core_clk,
	output logic [4:0]  s_axi_awaddr,
	output logic        s_axi_awvalid,
	input  wire logic        s_axi_awready,
	output logic [31:0] s_axi_wdata,
	output logic [3:0]  s_axi_wstrb,
	output logic        s_axi_wvalid,
	input  wire logic        s_axi_wready,
	input  wire logic        s_axi_bvalid,
	input  wire logic [1:0]  s_axi_bresp,
	output logic        s_axi_bready,
	output logic [4:0]  s_axi_araddr,
	output logic        s_axi_arvalid,
	input  wire logic        s_axi_arready,
	input  wire logic [31:0] s_axi_rdata,
	input  wire logic [1:0]  s_axi_rresp,
	input  wire logic        s_axi_rvalid,
	output logic        s_axi_rready
);
	int host_err = 0;
	logic [1:0] bresp_seen;
	initial begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hF;
	end

	// Caller keeps off the bus while the device is off
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic aw, w, b;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (int n = 0; n < 100; n++) begin
			// Sampled before the edge, acted on after it
			@(negedge core_clk);
			aw = s_axi_awvalid && s_axi_awready;
			w = s_axi_wvalid && s_axi_wready;
			b = s_axi_bvalid;
			if (b) bresp_seen = s_axi_bresp;
			@(posedge core_clk);
			if (aw) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
			if (b) break;
			if (n == 99) host_err++;
		end
		s_axi_bready <= 1'b0;
		@(posedge core_clk);
	endtask

	task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ar, v;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (int n = 0; n < 100; n++) begin
			@(negedge core_clk);
			ar = s_axi_arvalid && s_axi_arready;
			v = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge core_clk);
			if (ar) s_axi_arvalid <= 1'b0;
			if (v) break;
			if (n == 99) host_err++;
		end
		s_axi_rready <= 1'b0;
		@(posedge core_clk);
	endtask
endmodule
`default_nettype wire

//--- verif/mode_seq_tb.sv
// Self-checking bench for the mode sequencer.
// Assumes host_model and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "mode_seq_defs.vh"

module mode_seq_tb;
	logic        core_clk, arst_n, power_on_pin, power_on_pin_low;
	logic        preamble_ok, checks_ok, telegram_end;
	logic [4:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	logic        digital_supply_domain, analog_supply_domain, fast_rc_osc;
	logic        slow_rc_osc, crystal_osc, cpu_power_down, rx_path_en;
	logic        tx_path_en, data_accept, watchdog_restart;
	logic [31:0] d;
	logic [1:0]  r;
	int          fails = 0;
	int          cmp_count = 0;

	// Short init keeps the run brief
	mode_seq #(.INIT_CYCLES(4)) DUT (.*);
	host_model host (.*);

	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	// ****
	// Helpers
	// ****
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		cmp_count++;
		if (got !== exp) begin
			$display("CHECK FAILED %0t %s", $time, m);
			fails++;
		end
	endtask

	task automatic wait_state(input logic [2:0] s);
		for (int n = 0; n < 200; n++) begin
			host.rd(`REG_STATUS, d, r);
			if (d[2:0] === s) return;
		end
		chk(d[2:0], s, "state not reached");
	endtask

	task automatic wrap_up;
		fails += host.host_err;
		$display("checks %0d fails %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	// ****
	// Scenarios
	// ****
	task automatic t_off;
		arst_n <= 1'b0;
		repeat (5) @(posedge core_clk);
		arst_n <= 1'b1;
		repeat (20) @(posedge core_clk);
		chk({s_axi_awready, s_axi_arready, digital_supply_domain, crystal_osc}, 4'h0, "off");
		$display("off test done");
	endtask

	task automatic t_wake(input logic hi);
		if (hi) power_on_pin <= 1'b1;
		else power_on_pin_low <= 1'b0;
		repeat (8) @(posedge core_clk);
		power_on_pin <= 1'b0;
		power_on_pin_low <= 1'b1;
		wait_state(3'h2);
		chk(d[2:0], 3'h2, "not idle");
		host.rd(`REG_CFG, d, r);
		chk(d, `CFG_RESET, "cfg reset");
		chk({digital_supply_domain, analog_supply_domain, crystal_osc, slow_rc_osc}, 4'h9, "rc idle");
		$display("wake test done");
	endtask

	task automatic t_xtal;
		host.wr(`REG_CFG, 32'h0000_0003);
		repeat (4) @(posedge core_clk);
		chk({analog_supply_domain, crystal_osc, cpu_power_down}, 3'h7, "crystal idle");
		$display("crystal test done");
	endtask

	task automatic t_tx;
		host.wr(`REG_CTRL, 32'h0000_0001);
		wait_state(3'h3);
		host.wr(`REG_CTRL, 32'h0000_0002);
		host.rd(`REG_STATUS, d, r);
		chk(d[2:0], 3'h3, "command outside idle");
		repeat (20) @(posedge core_clk);
		chk({tx_path_en, rx_path_en}, 2'h2, "tx path");
		host.wr(`REG_CTRL, 32'h0000_0400);
		wait_state(3'h2);
		repeat (20) @(posedge core_clk);
		chk({tx_path_en, crystal_osc}, 2'h1, "back to idle");
		$display("tx test done");
	endtask

	task automatic t_rx;
		host.wr(`REG_CTRL, 32'h0000_0002);
		wait_state(3'h4);
		preamble_ok <= 1'b1;
		repeat (20) @(posedge core_clk);
		chk(data_accept, 1'b0, "accept w/o checks");
		checks_ok <= 1'b1;
		repeat (4) @(posedge core_clk);
		chk(data_accept, 1'b1, "no accept");
		preamble_ok <= 1'b0;
		checks_ok <= 1'b0;
		host.wr(`REG_CTRL, 32'h0000_0200);
		wait_state(3'h2);
		$display("rx test done");
	endtask

	task automatic t_map;
		host.rd(5'h14, d, r);
		chk({r, d}, {2'h2, 32'h0}, "unmapped");
		host.wr(5'h14, 32'h0000_0000);
		chk(host.bresp_seen, 2'h2, "unmapped write");
		host.rd(`REG_POLL, d, r);
		chk(d, `POLL_RESET, "poll reset");
		host.rd(`REG_WDOG, d, r);
		chk(d, `WDOG_RESET, "wdog reset");
		$display("map test done");
	endtask

	task automatic t_poll;
		int n;
		host.wr(`REG_CFG, 32'h0000_0202);
		host.wr(`REG_POLL, 32'h0001_0040);
		host.wr(`REG_CTRL, 32'h0000_0003);
		wait_state(3'h5);
		host.wr(`REG_POLL, 32'h0000_0000);
		chk(host.bresp_seen, 2'h0, "ignored write resp");
		host.rd(`REG_POLL, d, r);
		chk(d, 32'h0001_0040, "poll written outside idle");
		repeat (10) @(posedge core_clk);
		chk({rx_path_en, fast_rc_osc}, 2'h3, "listen window");
		d = 32'h0000_0000;
		for (n = 0; n < 100 && d[5] !== 1'b1; n++) host.rd(`REG_STATUS, d, r);
		chk(d[5], 1'b1, "no sleep phase");
		repeat (20) @(posedge core_clk);
		chk({rx_path_en, fast_rc_osc, cpu_power_down}, 3'h1, "sleep phase");
		wait_state(3'h6);
		wait_state(3'h5);
		telegram_end <= 1'b1;
		@(posedge core_clk);
		telegram_end <= 1'b0;
		wait_state(3'h2);
		host.wr(`REG_CTRL, 32'h0000_0004);
		wait_state(3'h6);
		wait_state(3'h2);
		$display("polling test done");
	endtask

	task automatic t_wdog;
		int n;
		host.wr(`REG_WDOG, 32'h0000_0040);
		for (n = 0; n < 300 && watchdog_restart !== 1'b1; n++) @(negedge core_clk);
		chk(n < 300, 1'b1, "no restart");
		@(posedge core_clk);
		wait_state(3'h2);
		host.wr(`REG_WDOG, 32'h0);
		$display("watchdog test done");
	endtask

	initial begin
		{arst_n, power_on_pin, preamble_ok, checks_ok, telegram_end} = '0;
		power_on_pin_low = 1'b1;
		@(posedge core_clk);
		t_off();
		t_wake(1'b0);
		t_xtal();
		t_tx();
		t_rx();
		t_map();
		t_poll();
		t_wdog();
		t_off();
		t_wake(1'b1);
		wrap_up();
	end

	initial begin
		repeat (50000) @(posedge core_clk);
		$display("CHECK FAILED %0t timeout", $time);
		fails++;
		wrap_up();
	end
endmodule
`default_nettype wire
